/* rtl/slpc_cfg.svh */
// constants for the lane power and low-swing control block
`ifndef SLPC_CFG_SVH
`define SLPC_CFG_SVH
`define SLPC_OFF_QUAD_CTL     12'h000
`define SLPC_OFF_TX_LANE_CTL  12'h004
`define SLPC_OFF_RX_EQ_BASE   12'h010
`define SLPC_OFF_LINK_CTL_2   12'h030
`define SLPC_OFF_LINK_STAT_2  12'h034
`define SLPC_OFF_LANE_STATUS  12'h038
`define SLPC_OFF_PORT_CTL     12'h03C
`define SLPC_BIT_LSE          0
`define SLPC_BIT_PWRDN        1
`define SLPC_LSG1_LSB         0
`define SLPC_LSG2_LSB         8
`define SLPC_RX_EQ_ZERO_LSB        0
`define SLPC_RX_EQ_BOOST_LSB        4
`define SLPC_SDE_BIT          6
`define SLPC_TM_LSB           7
`define SLPC_CDE_BIT          12
`define SLPC_RST_LSG1         4'h7
`define SLPC_RST_LSG2         4'h7
`define SLPC_RST_RXEQ         8'h00
`define SLPC_RST_LINK_CTL_2   32'h0000_0000
`define SLPC_RST_PORT_CTL     32'h0000_0001
`define SLPC_LANES            8
`define SLPC_QUADS            2
`endif

/* rtl/slpc_pkg.sv */
// types for the lane power and low-swing control block
package slpc_pkg;
   typedef enum logic [1:0] {
      SLPC_P0,
      SLPC_P1,
      SLPC_P2_OFF
   } slpc_lane_pwr_e;
   typedef enum logic [1:0] {
      SLPC_W_X1,
      SLPC_W_X2,
      SLPC_W_X4,
      SLPC_W_X8
   } slpc_width_e;
endpackage

/* rtl/slpc_axil.sv */
// axi4-lite slave front end producing register strobes
module slpc_axil
   import slpc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [11:0] awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [11:0] araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   output logic             wr_en,
   output logic [11:0]      wr_addr,
   output logic [31:0]      wr_data,
   output logic [3:0]       wr_strb,
   input  wire logic        wr_ok,
   output logic [11:0]      rd_addr,
   input  wire logic [31:0] rd_value,
   input  wire logic        rd_ok
);
   logic        aw_held, w_held, next_aw_held, next_w_held;
   logic [11:0] aw_q, next_aw_q;
   logic [31:0] w_q, next_w_q;
   logic [3:0]  s_q, next_s_q;
   logic        next_bvalid, next_rvalid;
   logic [1:0]  next_bresp, next_rresp;
   logic [31:0] next_rdata;

   assign awready = !aw_held && !bvalid;
   assign wready  = !w_held && !bvalid;
   assign arready = !rvalid;
   assign rd_addr = araddr;
   assign wr_en   = aw_held && w_held && !bvalid;
   assign wr_addr = aw_q;
   assign wr_data = w_q;
   assign wr_strb = s_q;

   always_comb begin
      next_aw_held = aw_held;
      next_w_held  = w_held;
      next_aw_q    = aw_q;
      next_w_q     = w_q;
      next_s_q     = s_q;
      next_bvalid  = bvalid;
      next_bresp   = bresp;
      next_rvalid  = rvalid;
      next_rresp   = rresp;
      next_rdata   = rdata;
      if (awvalid && awready) begin
         next_aw_held = 1'b1;
         next_aw_q    = awaddr;
      end
      if (wvalid && wready) begin
         next_w_held = 1'b1;
         next_w_q    = wdata;
         next_s_q    = wstrb;
      end
      if (wr_en) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = wr_ok ? 2'h0 : 2'h2;
      end else if (bvalid && bready) begin
         next_bvalid = 1'b0;
      end
      if (arvalid && arready) begin
         next_rvalid = 1'b1;
         next_rdata  = rd_ok ? rd_value : 32'h0000_0000;
         next_rresp  = rd_ok ? 2'h0 : 2'h2;
      end else if (rvalid && rready) begin
         next_rvalid = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_q    <= 12'h000;
         w_q     <= 32'h0000_0000;
         s_q     <= 4'h0;
         bvalid  <= 1'b0;
         bresp   <= 2'h0;
         rvalid  <= 1'b0;
         rresp   <= 2'h0;
         rdata   <= 32'h0000_0000;
      end else begin
         aw_held <= next_aw_held;
         w_held  <= next_w_held;
         aw_q    <= next_aw_q;
         w_q     <= next_w_q;
         s_q     <= next_s_q;
         bvalid  <= next_bvalid;
         bresp   <= next_bresp;
         rvalid  <= next_rvalid;
         rresp   <= next_rresp;
         rdata   <= next_rdata;
      end
   end
endmodule

/* rtl/slpc_lane_pwr.sv */
// per-lane power state decision for one port's lanes
`include "slpc_cfg.svh"
module slpc_lane_pwr
   import slpc_pkg::*;
(
   input  wire logic                      clk,
   input  wire logic                      rst,
   input  wire logic                      port_enable,
   input  wire slpc_width_e               port_width,
   input  wire logic [`SLPC_QUADS-1:0]    quad_power_down,
   input  wire logic                      in_detect,
   input  wire logic [`SLPC_LANES-1:0]    partner_detected,
   input  wire logic [`SLPC_LANES-1:0]    lane_active,
   output logic [`SLPC_LANES-1:0]         lane_used,
   output slpc_lane_pwr_e                 lane_state [`SLPC_LANES],
   output logic [`SLPC_QUADS-1:0]         quad_on
);
   logic [`SLPC_LANES-1:0] next_lane_used;
   logic [`SLPC_LANES-1:0] owned;
   slpc_lane_pwr_e         next_lane_state [`SLPC_LANES];
   logic [`SLPC_QUADS-1:0] next_quad_on;

   // lanes that belong to the port at its configured width
   function automatic logic [`SLPC_LANES-1:0] width_mask(input slpc_width_e w);
      unique case (w)
         SLPC_W_X1: width_mask = 8'h01;
         SLPC_W_X2: width_mask = 8'h03;
         SLPC_W_X4: width_mask = 8'h0F;
         SLPC_W_X8: width_mask = 8'hFF;
      endcase
   endfunction

   assign owned = width_mask(port_width);

   always_comb begin
      next_lane_used = lane_used;
      if (in_detect) begin
         next_lane_used = partner_detected & owned;
      end
      for (int q = 0; q < `SLPC_QUADS; q++) begin
         // quad off when port disabled or no owned lane
         next_quad_on[q] = port_enable && !quad_power_down[q] && (owned[q*4 +: 4] != 4'h0);
      end
      for (int l = 0; l < `SLPC_LANES; l++) begin
         if (!next_quad_on[l/4] || !port_enable || !owned[l]) begin
            // disabled lanes go deep low power
            next_lane_state[l] = SLPC_P2_OFF;
         end else if (!next_lane_used[l]) begin
            next_lane_state[l] = SLPC_P2_OFF;
         end else if (!lane_active[l] && !in_detect) begin
            next_lane_state[l] = SLPC_P1;
         end else begin
            next_lane_state[l] = SLPC_P0;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lane_used <= '0;
         quad_on   <= '0;
         for (int l = 0; l < `SLPC_LANES; l++) begin
            lane_state[l] <= SLPC_P2_OFF;
         end
      end else begin
         lane_used <= next_lane_used;
         quad_on   <= next_quad_on;
         for (int l = 0; l < `SLPC_LANES; l++) begin
            lane_state[l] <= next_lane_state[l];
         end
      end
   end
endmodule

/* rtl/slpc_top.sv */
// lane power and low-swing transmit control with axi4-lite registers
`include "slpc_cfg.svh"

// Notes on behaviour
// - low-swing enable bits of both quads select low-swing transmit, else full swing
// - low-swing reduces drive level and forces de-emphasis off
// - selectable and compliance de-emphasis fields ignored in low-swing
// - current de-emphasis status invalid in low-swing mode
// - gen1 low-swing drive from gen1 level code, 0x00 low to 0x0F high
// - gen2 low-swing drive from gen2 level code, 0x0F largest
// - compliance entry in low-swing uses margin field low-swing set
// - compliance entry in low-swing turns de-emphasis off
// - per-lane receiver equalization zero and boost controls held per lane
// - disabled x4 or x8 port puts its one or two quads deep low
// - disabled x1 or x2 port also turns quad 0 off, as for x4 or x8
// - quad whose lanes all belong to disabled ports goes deep low
// - enabled port: quads holding its lanes on, used lanes full power, unused lanes down
// - used lanes are those detected in detect, relearned on each detect
// - lanes dropped by downconfigure go to p1, idle tx, rx termination on
// - quad power-down bit powers whole quad down for every sharer
module slpc_top
   import slpc_pkg::*;
(
   input  wire logic          CLK,
   input  wire logic          RST,
   input  wire logic [11:0]   AWADDR,
   input  wire logic          AWVALID,
   output logic               AWREADY,
   input  wire logic [31:0]   WDATA,
   input  wire logic [3:0]    WSTRB,
   input  wire logic          WVALID,
   output logic               WREADY,
   output logic [1:0]         BRESP,
   output logic               BVALID,
   input  wire logic          BREADY,
   input  wire logic [11:0]   ARADDR,
   input  wire logic          ARVALID,
   output logic               ARREADY,
   output logic [31:0]        RDATA,
   output logic [1:0]         RRESP,
   output logic               RVALID,
   input  wire logic          RREADY,
   input  wire logic          GEN2_SPEED,
   input  wire logic          IN_COMPLIANCE,
   input  wire logic          IN_DETECT,
   input  wire logic [7:0]    PARTNER_DETECTED,
   input  wire logic [7:0]    LANE_ACTIVE,
   input  wire logic [1:0]    APPLIED_DEEMPH,
   output logic               TX_LOW_SWING,
   output logic [3:0]         TX_DRIVE_LEVEL,
   output logic               TX_MARGIN_LOW_SET,
   output logic               TX_DEEMPH_EN,
   output logic [1:0]         TX_DEEMPH_SEL,
   output logic [7:0]         RX_EQ_ZERO,
   output logic [31:0]        RX_EQ_BOOST,
   output logic [15:0]        LANE_PWR_STATE,
   output logic [7:0]         LANE_TX_IDLE,
   output logic [7:0]         LANE_RX_TERM,
   output logic [1:0]         QUAD_ON
);
   logic [11:0] wr_addr, rd_addr;
   logic [31:0] wr_data, rd_value;
   logic [3:0]  wr_strb;
   logic        wr_en, wr_ok, rd_ok;

   // per-quad control: low-swing enable, power-down
   logic [1:0]  low_swing_enable, next_low_swing_enable;
   logic [1:0]  quad_power_down, next_quad_power_down;
   logic [3:0]  low_swing_level_gen1, next_low_swing_level_gen1;
   logic [3:0]  low_swing_level_gen2, next_low_swing_level_gen2;
   logic [3:0]  full_swing_level, next_full_swing_level;
   logic [7:0]  rx_eq_lane_ctl [`SLPC_LANES];
   logic [7:0]  next_rx_eq_lane_ctl [`SLPC_LANES];
   logic        selectable_deemph, next_selectable_deemph;
   logic        compliance_deemph, next_compliance_deemph;
   logic [2:0]  transmit_margin_sel, next_transmit_margin_sel;
   logic        port_enable, next_port_enable;
   slpc_width_e port_width, next_port_width;
   logic        low_swing;

   logic [7:0]         lane_used;
   slpc_lane_pwr_e     lane_state [`SLPC_LANES];
   logic [1:0]         quad_on;

   slpc_axil u_axil (
      .clk      (CLK),
      .rst      (RST),
      .awaddr   (AWADDR),
      .awvalid  (AWVALID),
      .awready  (AWREADY),
      .wdata    (WDATA),
      .wstrb    (WSTRB),
      .wvalid   (WVALID),
      .wready   (WREADY),
      .bresp    (BRESP),
      .bvalid   (BVALID),
      .bready   (BREADY),
      .araddr   (ARADDR),
      .arvalid  (ARVALID),
      .arready  (ARREADY),
      .rdata    (RDATA),
      .rresp    (RRESP),
      .rvalid   (RVALID),
      .rready   (RREADY),
      .wr_en    (wr_en),
      .wr_addr  (wr_addr),
      .wr_data  (wr_data),
      .wr_strb  (wr_strb),
      .wr_ok    (wr_ok),
      .rd_addr  (rd_addr),
      .rd_value (rd_value),
      .rd_ok    (rd_ok)
   );

   slpc_lane_pwr u_pwr (
      .clk              (CLK),
      .rst              (RST),
      .port_enable      (port_enable),
      .port_width       (port_width),
      .quad_power_down  (quad_power_down),
      .in_detect        (IN_DETECT),
      .partner_detected (PARTNER_DETECTED),
      .lane_active      (LANE_ACTIVE),
      .lane_used        (lane_used),
      .lane_state       (lane_state),
      .quad_on          (quad_on)
   );

   // register index check shared by read and write decode
   function automatic logic is_mapped(input logic [11:0] a);
      is_mapped = (a[1:0] == 2'h0) && (a <= `SLPC_OFF_PORT_CTL) &&
                  !(a > `SLPC_OFF_TX_LANE_CTL && a < `SLPC_OFF_RX_EQ_BASE);
   endfunction

   assign wr_ok = is_mapped(wr_addr);
   assign rd_ok = is_mapped(rd_addr);

   // a port in low swing only when both quads agree; merged port needs both
   assign low_swing = &low_swing_enable;

   always_comb begin
      next_low_swing_enable     = low_swing_enable;
      next_quad_power_down      = quad_power_down;
      next_low_swing_level_gen1 = low_swing_level_gen1;
      next_low_swing_level_gen2 = low_swing_level_gen2;
      next_full_swing_level     = full_swing_level;
      next_selectable_deemph    = selectable_deemph;
      next_compliance_deemph    = compliance_deemph;
      next_transmit_margin_sel  = transmit_margin_sel;
      next_port_enable          = port_enable;
      next_port_width           = port_width;
      for (int l = 0; l < `SLPC_LANES; l++) begin
         next_rx_eq_lane_ctl[l] = rx_eq_lane_ctl[l];
      end
      // byte 0 lane here; byte 1 of the lane and link control registers is written below
      if (wr_en && wr_ok && wr_strb[0]) begin
         unique case (wr_addr)
            `SLPC_OFF_QUAD_CTL: begin
               next_low_swing_enable = {wr_data[`SLPC_BIT_LSE + 4], wr_data[`SLPC_BIT_LSE]};
               next_quad_power_down  = {wr_data[`SLPC_BIT_PWRDN + 4], wr_data[`SLPC_BIT_PWRDN]};
            end
            `SLPC_OFF_TX_LANE_CTL: begin
               next_low_swing_level_gen1 = wr_data[`SLPC_LSG1_LSB +: 4];
               next_full_swing_level     = wr_data[4 +: 4];
            end
            `SLPC_OFF_LINK_CTL_2: begin
               next_selectable_deemph = wr_data[`SLPC_SDE_BIT];
               next_transmit_margin_sel[0] = wr_data[`SLPC_TM_LSB];
            end
            `SLPC_OFF_PORT_CTL: begin
               next_port_enable = wr_data[0];
               next_port_width  = slpc_width_e'(wr_data[5:4]);
            end
            default: begin
               for (int l = 0; l < `SLPC_LANES; l++) begin
                  if (wr_addr == `SLPC_OFF_RX_EQ_BASE + 12'(4 * l)) begin
                     next_rx_eq_lane_ctl[l] = wr_data[7:0];
                  end
               end
            end
         endcase
      end
      if (wr_en && wr_ok && wr_strb[1]) begin
         if (wr_addr == `SLPC_OFF_TX_LANE_CTL) begin
            next_low_swing_level_gen2 = wr_data[`SLPC_LSG2_LSB +: 4];
         end
         if (wr_addr == `SLPC_OFF_LINK_CTL_2) begin
            next_transmit_margin_sel[2:1] = wr_data[`SLPC_TM_LSB + 1 +: 2];
            next_compliance_deemph        = wr_data[`SLPC_CDE_BIT];
         end
      end
   end

   always_comb begin
      rd_value = 32'h0000_0000;
      unique case (rd_addr)
         `SLPC_OFF_QUAD_CTL: begin
            rd_value[`SLPC_BIT_LSE]       = low_swing_enable[0];
            rd_value[`SLPC_BIT_PWRDN]     = quad_power_down[0];
            rd_value[`SLPC_BIT_LSE + 4]   = low_swing_enable[1];
            rd_value[`SLPC_BIT_PWRDN + 4] = quad_power_down[1];
         end
         `SLPC_OFF_TX_LANE_CTL: begin
            rd_value[`SLPC_LSG1_LSB +: 4] = low_swing_level_gen1;
            rd_value[4 +: 4]              = full_swing_level;
            rd_value[`SLPC_LSG2_LSB +: 4] = low_swing_level_gen2;
         end
         `SLPC_OFF_LINK_CTL_2: begin
            rd_value[`SLPC_SDE_BIT]       = selectable_deemph;
            rd_value[`SLPC_TM_LSB +: 3]   = transmit_margin_sel;
            rd_value[`SLPC_CDE_BIT]       = compliance_deemph;
         end
         // current de-emphasis reads as zero, invalid in low swing
         `SLPC_OFF_LINK_STAT_2: rd_value[1:0] = low_swing ? 2'h0 : APPLIED_DEEMPH;
         `SLPC_OFF_LANE_STATUS: rd_value[17:0] = {quad_on, LANE_PWR_STATE};
         `SLPC_OFF_PORT_CTL: rd_value[5:0] = {port_width, 3'h0, port_enable};
         default: begin
            for (int l = 0; l < `SLPC_LANES; l++) begin
               if (rd_addr == `SLPC_OFF_RX_EQ_BASE + 12'(4 * l)) begin
                  rd_value[7:0] = rx_eq_lane_ctl[l];
               end
            end
         end
      endcase
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         low_swing_enable     <= 2'h0;
         quad_power_down      <= 2'h0;
         low_swing_level_gen1 <= `SLPC_RST_LSG1;
         low_swing_level_gen2 <= `SLPC_RST_LSG2;
         full_swing_level     <= 4'hF;
         selectable_deemph    <= 1'b0;
         compliance_deemph    <= 1'b0;
         transmit_margin_sel  <= 3'h0;
         port_enable          <= 1'b1;
         port_width           <= SLPC_W_X8;
         for (int l = 0; l < `SLPC_LANES; l++) begin
            rx_eq_lane_ctl[l] <= `SLPC_RST_RXEQ;
         end
      end else begin
         low_swing_enable     <= next_low_swing_enable;
         quad_power_down      <= next_quad_power_down;
         low_swing_level_gen1 <= next_low_swing_level_gen1;
         low_swing_level_gen2 <= next_low_swing_level_gen2;
         full_swing_level     <= next_full_swing_level;
         selectable_deemph    <= next_selectable_deemph;
         compliance_deemph    <= next_compliance_deemph;
         transmit_margin_sel  <= next_transmit_margin_sel;
         port_enable          <= next_port_enable;
         port_width           <= next_port_width;
         for (int l = 0; l < `SLPC_LANES; l++) begin
            rx_eq_lane_ctl[l] <= next_rx_eq_lane_ctl[l];
         end
      end
   end

   // transmit controls, registered like the data outputs
   logic [3:0] next_drive;
   logic       next_deemph_en, next_margin_low;
   logic [1:0] next_deemph_sel;
   always_comb begin
      next_margin_low = 1'b0;
      next_deemph_sel = {compliance_deemph, selectable_deemph};
      if (low_swing) begin
         next_drive     = GEN2_SPEED ? low_swing_level_gen2 : low_swing_level_gen1;
         next_deemph_en  = 1'b0;
         next_deemph_sel = 2'h0;
         if (IN_COMPLIANCE) begin
            next_drive      = {1'b0, transmit_margin_sel};
            next_margin_low = 1'b1;
         end
      end else begin
         next_drive     = IN_COMPLIANCE ? {1'b0, transmit_margin_sel} : full_swing_level;
         next_deemph_en = 1'b1;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         TX_LOW_SWING      <= 1'b0;
         TX_DRIVE_LEVEL    <= 4'hF;
         TX_DEEMPH_EN      <= 1'b1;
         TX_DEEMPH_SEL     <= 2'h0;
         TX_MARGIN_LOW_SET <= 1'b0;
      end else begin
         TX_LOW_SWING      <= low_swing;
         TX_DRIVE_LEVEL    <= next_drive;
         TX_DEEMPH_EN      <= next_deemph_en;
         TX_DEEMPH_SEL     <= next_deemph_sel;
         TX_MARGIN_LOW_SET <= next_margin_low;
      end
   end

   for (genvar l = 0; l < `SLPC_LANES; l++) begin : g_lane
      assign RX_EQ_ZERO[l]          = rx_eq_lane_ctl[l][`SLPC_RX_EQ_ZERO_LSB];
      assign RX_EQ_BOOST[4*l +: 4]  = rx_eq_lane_ctl[l][`SLPC_RX_EQ_BOOST_LSB +: 4];
      assign LANE_PWR_STATE[2*l +: 2] = lane_state[l];
      // p1 lanes idle tx, keep rx termination
      assign LANE_TX_IDLE[l]        = (lane_state[l] != SLPC_P0);
      assign LANE_RX_TERM[l]        = (lane_state[l] != SLPC_P2_OFF);
   end
   assign QUAD_ON = quad_on;
endmodule

/* tb/slpc_properties.sv */
// concurrent checks on the ports of the lane power and low-swing block
module slpc_properties (
   input  wire logic        CLK,
   input  wire logic        RST,
   input  wire logic        BVALID,
   input  wire logic        BREADY,
   input  wire logic [1:0]  BRESP,
   input  wire logic        RVALID,
   input  wire logic        RREADY,
   input  wire logic [31:0] RDATA,
   input  wire logic        IN_COMPLIANCE,
   input  wire logic [7:0]  LANE_ACTIVE,
   input  wire logic        TX_LOW_SWING,
   input  wire logic        TX_MARGIN_LOW_SET,
   input  wire logic        TX_DEEMPH_EN,
   input  wire logic [1:0]  TX_DEEMPH_SEL,
   input  wire logic [15:0] LANE_PWR_STATE,
   input  wire logic [7:0]  LANE_TX_IDLE,
   input  wire logic [7:0]  LANE_RX_TERM,
   input  wire logic [1:0]  QUAD_ON
);
   default clocking @(posedge CLK);
   endclocking
   default disable iff (RST);
   AST_LS_NO_DEEMPH: assert property (TX_LOW_SWING |-> !TX_DEEMPH_EN && TX_DEEMPH_SEL == 2'h0)
      else $error("deemphasis active in low swing");
   AST_COMPL_OFF: assert property (TX_MARGIN_LOW_SET |-> TX_LOW_SWING && !TX_DEEMPH_EN)
      else $error("bad margin set");
   AST_COMPL_LOW: assert property ($past(IN_COMPLIANCE) && TX_LOW_SWING && $past(TX_LOW_SWING) |-> TX_MARGIN_LOW_SET)
      else $error("low margin set missing");
   AST_P1_INACTIVE: assert property (LANE_PWR_STATE[7:6] == 2'h1 |-> !$past(LANE_ACTIVE[3]))
      else $error("lane in p1 while active");
   AST_P1_IDLE_TERM: assert property (LANE_PWR_STATE[7:6] == 2'h1 |-> LANE_TX_IDLE[3] && LANE_RX_TERM[3])
      else $error("p1 lane not idle with termination");
   AST_OFF_LANE: assert property (LANE_PWR_STATE[1:0] == 2'h2 |-> LANE_TX_IDLE[0] && !LANE_RX_TERM[0])
      else $error("deep low lane still terminated");
   AST_QUAD_OFF_LANES: assert property (!QUAD_ON[1] |-> LANE_PWR_STATE[15:8] == 8'hAA)
      else $error("lane powered in an unpowered quad");
   AST_P0_NEEDS_QUAD: assert property (LANE_PWR_STATE[1:0] == 2'h0 |-> QUAD_ON[0])
      else $error("full power lane with quad off");
   AST_BVALID_HOLD: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
      else $error("write response dropped early");
   AST_RVALID_HOLD: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
      else $error("read data dropped early");
   cover property (TX_MARGIN_LOW_SET);
   cover property (LANE_PWR_STATE[7:6] == 2'h1);
   cover property (QUAD_ON == 2'h1);
endmodule

bind slpc_top slpc_properties u_props (.*);

/* tb/slpc_link_partner.sv */
// link partner: presence seen in detect, lane activity after training
module slpc_link_partner (
   input  wire logic       CLK,
   input  wire logic       RST,
   input  wire logic       det_req,
   input  wire logic [7:0] det_mask,
   input  wire logic [7:0] act_mask,
   output logic            IN_DETECT,
   output logic [7:0]      PARTNER_DETECTED,
   output logic [7:0]      LANE_ACTIVE
);
   timeunit 1ns;
   timeprecision 1ns;
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         IN_DETECT <= 1'h0;
         PARTNER_DETECTED <= 8'h00;
         LANE_ACTIVE <= 8'h00;
      end else begin
         IN_DETECT <= det_req;
         PARTNER_DETECTED <= det_req ? det_mask : ~PARTNER_DETECTED;
         LANE_ACTIVE <= det_req ? 8'h00 : act_mask;
      end
   end
endmodule

/* tb/slpc_top_test.sv */
// self-checking bench for the lane power and low-swing block
`include "slpc_cfg.svh"
module slpc_top_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic        CLK = 1'h0, RST = 1'h1, AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h1, ARVALID = 1'h0;
   logic        RREADY = 1'h1, GEN2_SPEED = 1'h0, IN_COMPLIANCE = 1'h0, det_req = 1'h0;
   logic        IN_DETECT, AWREADY, WREADY, BVALID, ARREADY, RVALID, TX_LOW_SWING, TX_MARGIN_LOW_SET, TX_DEEMPH_EN;
   logic [1:0]  APPLIED_DEEMPH = 2'h3, BRESP, RRESP, rr, TX_DEEMPH_SEL, QUAD_ON;
   logic [3:0]  WSTRB = 4'hF, TX_DRIVE_LEVEL, g1, g2;
   logic [7:0]  det_mask = '0, act_mask = '0, PARTNER_DETECTED, LANE_ACTIVE, RX_EQ_ZERO, LANE_TX_IDLE, LANE_RX_TERM;
   logic [11:0] AWADDR = '0, ARADDR = '0;
   logic [15:0] LANE_PWR_STATE;
   logic [31:0] WDATA = '0, RDATA, RX_EQ_BOOST, rv;
   int          fails = 0, check_count = 0;
   slpc_top u_dut (.*);
   slpc_link_partner u_peer (.*);
   initial forever #5 CLK = ~CLK;
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   // write: both channels offered together, each released when taken
   task automatic wr(logic [11:0] a, logic [31:0] d);
      int n = 0;
      AWADDR <= a;
      WDATA <= d;
      AWVALID <= 1'h1;
      WVALID <= 1'h1;
      do begin
         @(posedge CLK);
         if (AWREADY) AWVALID <= 1'h0;
         if (WREADY) WVALID <= 1'h0;
         n++;
      end while (BVALID !== 1'h1 && n < 50);
      if (n >= 50) begin
         fails++;
         conclude();
      end
   endtask
   task automatic rd(logic [11:0] a);
      int n = 0;
      ARADDR <= a;
      ARVALID <= 1'h1;
      do begin
         @(posedge CLK);
         if (ARREADY) ARVALID <= 1'h0;
         n++;
      end while (RVALID !== 1'h1 && n < 50);
      rv = RDATA;
      rr = RRESP;
      if (n >= 50) begin
         fails++;
         conclude();
      end
   endtask
   function automatic logic [15:0] exp_lanes(logic [7:0] u, logic [7:0] a);
      logic [15:0] r;
      for (int i = 0; i < 8; i++) r[2*i+:2] = !u[i] ? 2'h2 : (a[i] ? 2'h0 : 2'h1);
      return r;
   endfunction
   task automatic train(logic [7:0] m);
      det_mask <= m;
      act_mask <= m;
      det_req <= 1'h1;
      repeat (4) @(posedge CLK);
      det_req <= 1'h0;
      repeat (3) @(posedge CLK);
      chk("lane states", exp_lanes(m, m), LANE_PWR_STATE);
   endtask
   initial begin
      void'($urandom(32'h4E130212));
      repeat (5) @(posedge CLK);
      RST <= 1'h0;
      @(posedge CLK);
      rd(`SLPC_OFF_TX_LANE_CTL);
      chk("tx lane ctl", 32'h7F7, rv);
      rd(`SLPC_OFF_PORT_CTL);
      chk("port ctl", 32'h31, rv);
      rd(12'h100);
      chk("unmapped resp", 2'h2, rr);
      $display("test reset values done");
      // both serdes of the merged port enabled
      wr(`SLPC_OFF_QUAD_CTL, 32'h11);
      for (int k = 0; k < 8; k++) begin
         g1 = k < 4 ? {4{k[1]}} : 4'($urandom);
         g2 = k < 4 ? ~g1 : 4'($urandom);
         wr(`SLPC_OFF_TX_LANE_CTL, {20'h0, g2, 4'hF, g1});
         GEN2_SPEED <= k[0];
         repeat (3) @(posedge CLK);
         chk("low swing", 1'h1, TX_LOW_SWING);
         chk("drive", k[0] ? g2 : g1, TX_DRIVE_LEVEL);
         chk("deemph en", 1'h0, TX_DEEMPH_EN);
      end
      wr(`SLPC_OFF_LINK_CTL_2, 32'h1040);
      rd(`SLPC_OFF_LINK_STAT_2);
      chk("deemph sel", 2'h0, TX_DEEMPH_SEL);
      chk("current deemph", 2'h0, rv[1:0]);
      // only one serdes enabled is not a low-swing port
      wr(`SLPC_OFF_QUAD_CTL, 32'h01);
      rd(`SLPC_OFF_LINK_STAT_2);
      chk("low swing", 1'h0, TX_LOW_SWING);
      chk("full drive", 4'hF, TX_DRIVE_LEVEL);
      chk("deemph sel", 2'h3, TX_DEEMPH_SEL);
      chk("current deemph", 2'h3, rv[1:0]);
      wr(`SLPC_OFF_QUAD_CTL, 32'h11);
      wr(`SLPC_OFF_LINK_CTL_2, 32'h12C0);
      IN_COMPLIANCE <= 1'h1;
      repeat (3) @(posedge CLK);
      chk("margin low set", 1'h1, TX_MARGIN_LOW_SET);
      chk("compliance drive", 4'h5, TX_DRIVE_LEVEL);
      chk("compliance deemph", 1'h0, TX_DEEMPH_EN);
      IN_COMPLIANCE <= 1'h0;
      $display("test low swing done");
      for (int l = 0; l < 8; l++) begin
         g1 = 4'($urandom);
         g2 = 4'($urandom);
         wr(`SLPC_OFF_RX_EQ_BASE + 12'(4 * l), {24'h0, g1, 3'h0, g2[0]});
         repeat (2) @(posedge CLK);
         chk("eq zero", g2[0], RX_EQ_ZERO[l]);
         chk("eq boost", g1, RX_EQ_BOOST[4*l+:4]);
      end
      $display("test equalization done");
      train(8'($urandom));
      train(8'h0F);
      chk("quads on", 2'h3, QUAD_ON);
      act_mask <= 8'h03;
      repeat (3) @(posedge CLK);
      chk("downconfig", exp_lanes(8'h0F, 8'h03), LANE_PWR_STATE);
      chk("tx idle", 8'hFC, LANE_TX_IDLE);
      chk("rx term", 8'h0F, LANE_RX_TERM);
      wr(`SLPC_OFF_QUAD_CTL, 32'h20);
      repeat (2) @(posedge CLK);
      chk("quad power down", 2'h1, QUAD_ON);
      chk("quad1 lanes", 8'hAA, LANE_PWR_STATE[15:8]);
      $display("test lane power done");
      for (int w = 0; w < 4; w++) begin
         wr(`SLPC_OFF_PORT_CTL, 32'(w << 4));
         repeat (2) @(posedge CLK);
         chk("disabled lane0", 2'h2, LANE_PWR_STATE[1:0]);
         if (w > 1) chk("quad0", 1'h0, QUAD_ON[0]);
         if (w == 3) chk("quad1", 1'h0, QUAD_ON[1]);
      end
      $display("test port disable done");
      conclude();
   end
endmodule
